// *** shared/tscp_pkg.sv ***
// Shared constants, types and helper functions for the three-wire serial control port
package tscp_pkg;
  // Instruction word layout
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 13;
  localparam int POS_DIR = 15;
  localparam int POS_LEN_HI = 14;
  localparam int POS_LEN_LO = 13;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  // Length codes
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // Register map
  localparam int REG_COUNT = 53;
  localparam int ADDR_IDX_W = 6;
  localparam logic [12:0] LAST_ADDR = 13'h0034;
  localparam logic [12:0] REG_PORT_CFG = 13'h0000;
  localparam logic [12:0] REG_READBACK = 13'h0004;
  localparam logic [12:0] REG_IO_UPDATE = 13'h0005;
  localparam logic [12:0] REG_STATUS = 13'h0034;
  // Field positions
  localparam int POS_LSB_FIRST = 6;
  localparam int POS_LSB_FIRST_MIRROR = 1;
  localparam int POS_IO_UPDATE = 0;
  localparam int POS_READ_SHADOW = 0;
  // Reset values
  localparam logic [7:0] PORT_CFG_RESET = 8'h18;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Frequency-selection pins, all held high for serial access
  localparam int FREQ_PINS = 9;
  localparam logic [8:0] FREQ_PINS_HIGH = 9'h1FF;
  // Serial clock made by the host end
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  // Device end states
  typedef enum logic [1:0] {DV_IDLE, DV_INSTR, DV_DATA, DV_DONE} tscp_dev_state_t;
  // Host end states
  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END, HS_GAP} tscp_host_state_t;

  // Bit of a byte sent at position idx in the chosen order
  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] idx, input logic lsb);
    pick_bit = lsb ? b[idx] : b[3'h7 - idx];
  endfunction

  // Byte assembled by shifting one more bit in, in the chosen order
  function automatic logic [7:0] shift8(input logic [7:0] b, input logic d, input logic lsb);
    shift8 = lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction
endpackage

// *** shared/tscp_if.sv ***
// Pin-level link between the host end and the device end of the serial port
`timescale 1ns/100ps
interface tscp_if;
  import tscp_pkg::*;
  logic sclk; // Serial clock from host
  logic cs_n; // Chip select, active low
  logic host_sdio_o; // Host data out
  logic host_sdio_oe; // Host drives data line
  logic dev_sdio_o; // Device data out
  logic dev_sdio_oe; // Device drives data line
  logic [FREQ_PINS-1:0] freq_sel; // Frequency-selection pins
  logic sdio; // Resolved data line level

  // Released line floats to a pulled-up idle level
  assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);

  modport host (output sclk, cs_n, host_sdio_o, host_sdio_oe, freq_sel, input sdio);
  modport dev (input sclk, cs_n, sdio, freq_sel, output dev_sdio_o, dev_sdio_oe);
endinterface

// *** logic/tscp_dev_end.sv ***
// Device end of the three-wire serial control port with shadowed register file
//
// Overview of operation
// - Host ties frequency pins high for access
// - Read-only registers ignore write commands
// - Writes land in shadow until update
// - Update bit copies all shadows at once
// - Sample on rise, launch read on fall
// - Data line released while chip select high
// - Host lowers chip select per cycle
// - Host never stalls; device waits at instruction byte boundary and at short-length data byte boundaries
// - Stall at byte boundary keeps progress
// - Short abort pulse resets state machine
// - Mid-byte chip select rise flushes port
// - Length code gives one to three bytes
// - Code three streams with address stepping
// - First sixteen rises shift in instruction
// - Direction zero writes data bytes
// - Rise after final write byte ends cycle
// - Either bit order, single or multibyte
// - Direction, length, thirteen address bits
// - Direction one drives register bytes out
// - MSB-first decrements, LSB-first increments address
// - Update of order bit switches order
`timescale 1ns/100ps
module tscp_dev_end
  import tscp_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes state when low
  tscp_if.dev port, // Serial pins
  output logic o_lsb_first, // Active bit order is LSB first
  output logic o_read_shadow, // Reads return shadow contents
  output logic o_io_update, // One-cycle pulse on each update
  output logic [7:0] o_update_count, // Number of updates taken
  output logic o_busy // Communication cycle in progress
);

  // Pin synchronisers
  logic sclk_q1_r, sclk_q2_r, sclk_q3_r; // Serial clock stages and edge history
  logic cs_q1_r, cs_q2_r; // Chip select stages
  logic sdi_q1_r, sdi_q2_r; // Data line stages
  logic [FREQ_PINS-1:0] fs_q1_r, fs_q2_r; // Frequency pin stages

  // Port state
  tscp_dev_state_t state_r, state_nxt; // Port state machine
  logic [3:0] cnt_r, cnt_nxt; // Bit count in instruction or byte
  logic [15:0] instr_r, instr_nxt; // Instruction being assembled
  logic [7:0] rx_r, rx_nxt; // Data byte being assembled
  logic [12:0] addr_r, addr_nxt; // Current register address
  logic [1:0] len_r, len_nxt; // Length code of the cycle
  logic [1:0] left_r, left_nxt; // Data bytes still to come after this one
  logic dir_r, dir_nxt; // Direction flag, high for read
  logic [7:0] tx_r, tx_nxt; // Byte being read out
  logic sdo_r, sdo_nxt; // Registered data line output
  logic oe_r, oe_nxt; // Registered data line enable
  logic upd_r; // Registered update pulse
  logic [7:0] upd_cnt_r, upd_cnt_nxt; // Update counter, read-only register

  // Register file
  logic [7:0] active_r [0:REG_COUNT-1]; // Registers in use
  logic [7:0] shadow_r [0:REG_COUNT-1]; // Buffered copies

  // Combinational helpers
  logic rise, fall; // Serial clock edges
  logic cs_hi; // Chip select high or port disabled
  logic lsb; // Active bit order
  logic [7:0] byte_in; // Byte including the bit now sampled
  logic [15:0] instr_in; // Instruction including the bit now sampled
  logic [12:0] rd_addr; // Address of the next byte to read out
  logic [7:0] rd_byte; // Contents at rd_addr
  logic wr_en; // Shadow write strobe
  logic [ADDR_IDX_W-1:0] wr_idx; // Shadow write index
  logic upd; // Update request

  // Step address after each byte, direction from bit order
  function automatic logic [12:0] step_addr(input logic [12:0] a, input logic l);
    step_addr = l ? a + 13'h0001 : a - 13'h0001;
  endfunction

  // Two flip-flops on every pin before any logic reads it
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_q1_r <= 1'b0;
      sclk_q2_r <= 1'b0;
      sclk_q3_r <= 1'b0;
      cs_q1_r <= 1'b1;
      cs_q2_r <= 1'b1;
      sdi_q1_r <= 1'b0;
      sdi_q2_r <= 1'b0;
      fs_q1_r <= '0;
      fs_q2_r <= '0;
    end
    else if (i_ce)
    begin
      sclk_q1_r <= port.sclk;
      sclk_q2_r <= sclk_q1_r;
      sclk_q3_r <= sclk_q2_r;
      cs_q1_r <= port.cs_n;
      cs_q2_r <= cs_q1_r;
      sdi_q1_r <= port.sdio;
      sdi_q2_r <= sdi_q1_r;
      fs_q1_r <= port.freq_sel;
      fs_q2_r <= fs_q1_r;
    end
  end

  // Edges and port enable
  assign rise = sclk_q2_r & ~sclk_q3_r;
  assign fall = ~sclk_q2_r & sclk_q3_r;
  assign cs_hi = cs_q2_r | (fs_q2_r != FREQ_PINS_HIGH);
  assign lsb = active_r[REG_PORT_CFG[ADDR_IDX_W-1:0]][POS_LSB_FIRST]
    | active_r[REG_PORT_CFG[ADDR_IDX_W-1:0]][POS_LSB_FIRST_MIRROR];

  // Read mux over active or shadow copies
  always_comb
  begin
    rd_byte = 8'h00; // Unmapped and update register read zero
    if (rd_addr == REG_STATUS)
      rd_byte = upd_cnt_r;
    else if (rd_addr <= LAST_ADDR)
      rd_byte = active_r[REG_READBACK[ADDR_IDX_W-1:0]][POS_READ_SHADOW]
        ? shadow_r[rd_addr[ADDR_IDX_W-1:0]] : active_r[rd_addr[ADDR_IDX_W-1:0]];
  end

  // Port state machine next values
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    instr_nxt = instr_r;
    rx_nxt = rx_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    left_nxt = left_r;
    dir_nxt = dir_r;
    tx_nxt = tx_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    upd_cnt_nxt = upd_cnt_r;
    wr_en = 1'b0;
    upd = 1'b0;
    wr_idx = addr_r[ADDR_IDX_W-1:0];
    byte_in = shift8(rx_r, sdi_q2_r, lsb);
    instr_in = lsb ? {sdi_q2_r, instr_r[15:1]} : {instr_r[14:0], sdi_q2_r};
    rd_addr = (state_r == DV_INSTR) ? instr_in[ADDR_W-1:0] : step_addr(addr_r, lsb);
    if (cs_hi)
    begin
      oe_nxt = 1'b0;
      case (state_r)
        DV_INSTR:
          // Mid-byte rise flushes, boundary rise waits
          if (cnt_r[2:0] != BIT_FIRST || cnt_r == 4'h0)
            state_nxt = DV_IDLE;
        DV_DATA:
          if (cnt_r[2:0] != BIT_FIRST || len_r == LEN_STREAM)
            state_nxt = DV_IDLE;
          else
            state_nxt = DV_DATA;
        DV_DONE:
          state_nxt = DV_IDLE;
        default:
          state_nxt = DV_IDLE;
      endcase
      if (state_nxt == DV_IDLE)
      begin
        cnt_nxt = 4'h0;
        rx_nxt = 8'h00;
      end
    end
    else
    begin
      case (state_r)
        DV_IDLE:
        begin
          // Chip select low opens a new cycle
          state_nxt = DV_INSTR;
          cnt_nxt = 4'h0;
        end
        DV_INSTR:
          if (rise)
          begin
            instr_nxt = instr_in;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == INSTR_LAST)
            begin
              // Decode direction, length and start address
              state_nxt = DV_DATA;
              cnt_nxt = 4'h0;
              dir_nxt = instr_in[POS_DIR];
              len_nxt = instr_in[POS_LEN_HI:POS_LEN_LO];
              left_nxt = instr_in[POS_LEN_HI:POS_LEN_LO];
              addr_nxt = instr_in[ADDR_W-1:0];
              tx_nxt = rd_byte;
            end
          end
        DV_DATA:
        begin
          if (rise)
          begin
            rx_nxt = byte_in;
            cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
            if (cnt_r[2:0] == BIT_LAST)
            begin
              cnt_nxt = 4'h0;
              if (!dir_r)
              begin
                if (addr_r == REG_IO_UPDATE)
                  upd = byte_in[POS_IO_UPDATE];
                else if (addr_r <= LAST_ADDR && addr_r != REG_STATUS)
                  wr_en = 1'b1;
              end
              addr_nxt = rd_addr;
              tx_nxt = rd_byte;
              if (len_r != LEN_STREAM)
              begin
                if (left_r == 2'h0)
                  state_nxt = DV_DONE;
                else
                  left_nxt = left_r - 2'h1;
              end
            end
          end
          if (fall && dir_r)
          begin
            sdo_nxt = pick_bit(tx_r, cnt_r[2:0], lsb);
            oe_nxt = 1'b1;
          end
        end
        DV_DONE:
          // Last read bit stays until the host has seen its falling edge
          if (fall)
            oe_nxt = 1'b0;
        default:
          state_nxt = DV_IDLE;
      endcase
    end
    if (upd)
      upd_cnt_nxt = upd_cnt_r + 8'h01;
  end

  // Port state registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= DV_IDLE;
      cnt_r <= 4'h0;
      instr_r <= 16'h0000;
      rx_r <= 8'h00;
      addr_r <= 13'h0000;
      len_r <= 2'h0;
      left_r <= 2'h0;
      dir_r <= 1'b0;
      tx_r <= 8'h00;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      upd_r <= 1'b0;
      upd_cnt_r <= 8'h00;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      instr_r <= instr_nxt;
      rx_r <= rx_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      left_r <= left_nxt;
      dir_r <= dir_nxt;
      tx_r <= tx_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      upd_r <= upd;
      upd_cnt_r <= upd_cnt_nxt;
    end
  end

  // Shadow writes and simultaneous copy to active registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        active_r[i] <= (i == int'(REG_PORT_CFG)) ? PORT_CFG_RESET : REG_RESET;
        shadow_r[i] <= (i == int'(REG_PORT_CFG)) ? PORT_CFG_RESET : REG_RESET;
      end
    end
    else if (i_ce)
    begin
      if (wr_en)
        shadow_r[wr_idx] <= byte_in;
      if (upd)
        for (int i = 0; i < REG_COUNT; i++)
          active_r[i] <= shadow_r[i];
    end
  end

  // Pins and user-side outputs
  assign port.dev_sdio_o = sdo_r;
  assign port.dev_sdio_oe = oe_r;
  assign o_lsb_first = lsb;
  assign o_read_shadow = active_r[REG_READBACK[ADDR_IDX_W-1:0]][POS_READ_SHADOW];
  assign o_io_update = upd_r;
  assign o_update_count = upd_cnt_r;
  assign o_busy = (state_r != DV_IDLE);
endmodule

// *** logic/tscp_host_end.sv ***
// Host end of the three-wire serial control port: makes the serial clock and frames cycles
`timescale 1ns/100ps
module tscp_host_end
  import tscp_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes state when low
  tscp_if.host port, // Serial pins
  input wire logic i_start, // Start a cycle, taken when idle
  input wire logic i_read, // Direction flag, high for read
  input wire logic [1:0] i_len, // Length code
  input wire logic [12:0] i_addr, // Start address field
  input wire logic [7:0] i_nbytes, // Byte count for streaming, at least one
  input wire logic i_lsb_first, // Send in LSB-first order
  input wire logic [7:0] i_wdata, // Write byte, taken at o_wtake
  output logic o_wtake, // Pulse, i_wdata loaded
  output logic [7:0] o_rdata, // Read byte
  output logic o_rvalid, // Pulse, o_rdata new
  output logic o_busy, // Cycle in progress
  output logic o_done // Pulse, cycle finished
);

  tscp_host_state_t state_r, state_nxt; // Cycle sequencer
  logic [3:0] tick_r, tick_nxt; // Half-period counter
  logic [11:0] bit_r, bit_nxt; // Bit index within the cycle
  logic [11:0] last_r, last_nxt; // Index of the final bit
  logic [15:0] instr_r, instr_nxt; // Instruction word
  logic [7:0] wbyte_r, wbyte_nxt; // Write byte being sent
  logic [7:0] rbyte_r, rbyte_nxt; // Read byte being gathered
  logic rd_r, rd_nxt; // Cycle is a read
  logic lsb_r, lsb_nxt; // Bit order of this cycle
  logic sclk_r, sclk_nxt; // Serial clock out
  logic cs_n_r, cs_n_nxt; // Chip select out
  logic sdo_r, sdo_nxt; // Data out
  logic oe_r, oe_nxt; // Data drive enable
  logic wtake_r, wtake_nxt; // Write byte taken pulse
  logic rvalid_r, rvalid_nxt; // Read byte pulse
  logic done_r, done_nxt; // Done pulse
  logic [7:0] rdata_r, rdata_nxt; // Read byte output
  logic sdi_q1_r, sdi_q2_r; // Data line synchroniser
  logic [11:0] nb; // Data bytes in the cycle
  logic [11:0] nxt_bit; // Following bit index
  logic [7:0] nxt_wbyte; // Byte source for the following bit

  // Bit to send at an index
  function automatic logic out_bit(input logic [11:0] idx, input logic [15:0] ins,
    input logic [7:0] wb, input logic l);
    if (idx < 12'(INSTR_BITS))
      out_bit = l ? ins[idx[3:0]] : ins[4'hF - idx[3:0]];
    else
      out_bit = pick_bit(wb, idx[2:0], l);
  endfunction

  // Data line passes two flip-flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sdi_q1_r <= 1'b0;
      sdi_q2_r <= 1'b0;
    end
    else if (i_ce)
    begin
      sdi_q1_r <= port.sdio;
      sdi_q2_r <= sdi_q1_r;
    end
  end

  // Sequencer next values
  always_comb
  begin
    state_nxt = state_r;
    tick_nxt = tick_r + 4'h1;
    bit_nxt = bit_r;
    last_nxt = last_r;
    instr_nxt = instr_r;
    wbyte_nxt = wbyte_r;
    rbyte_nxt = rbyte_r;
    rd_nxt = rd_r;
    lsb_nxt = lsb_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wtake_nxt = 1'b0;
    rvalid_nxt = 1'b0;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    nb = (i_len == LEN_STREAM) ? {4'h0, i_nbytes} : {10'h000, i_len} + 12'h001;
    nxt_bit = bit_r + 12'h001;
    nxt_wbyte = (nxt_bit[2:0] == BIT_FIRST) ? i_wdata : wbyte_r;
    case (state_r)
      HS_IDLE:
      begin
        tick_nxt = 4'h0;
        if (i_start)
        begin
          // Open the cycle with the first instruction bit
          instr_nxt = {i_read, i_len, i_addr};
          rd_nxt = i_read;
          lsb_nxt = i_lsb_first;
          last_nxt = 12'(INSTR_BITS) + (nb << 3) - 12'h001;
          bit_nxt = 12'h000;
          cs_n_nxt = 1'b0;
          oe_nxt = 1'b1;
          sdo_nxt = out_bit(12'h000, {i_read, i_len, i_addr}, wbyte_r, i_lsb_first);
          state_nxt = HS_LOW;
        end
      end
      HS_LOW:
        if (tick_r == HALF_LAST)
        begin
          sclk_nxt = 1'b1;
          tick_nxt = 4'h0;
          state_nxt = HS_HIGH;
        end
      HS_HIGH:
        if (tick_r == HALF_LAST)
        begin
          sclk_nxt = 1'b0;
          tick_nxt = 4'h0;
          if (rd_r && bit_r >= 12'(INSTR_BITS))
          begin
            // Read bit launched on the previous fall is sampled here
            rbyte_nxt = shift8(rbyte_r, sdi_q2_r, lsb_r);
            if (bit_r[2:0] == BIT_LAST)
            begin
              rdata_nxt = shift8(rbyte_r, sdi_q2_r, lsb_r);
              rvalid_nxt = 1'b1;
            end
          end
          if (bit_r == last_r)
            state_nxt = HS_END;
          else
          begin
            // Change data on the falling edge
            bit_nxt = nxt_bit;
            state_nxt = HS_LOW;
            if (!rd_r && nxt_bit[2:0] == BIT_FIRST && nxt_bit >= 12'(INSTR_BITS))
            begin
              wbyte_nxt = i_wdata;
              wtake_nxt = 1'b1;
            end
            oe_nxt = !(rd_r && nxt_bit >= 12'(INSTR_BITS));
            sdo_nxt = out_bit(nxt_bit, instr_r, nxt_wbyte, lsb_r);
          end
        end
      HS_END:
        if (tick_r == HALF_LAST)
        begin
          // Chip select rises only after the final byte, never for a stall
          cs_n_nxt = 1'b1;
          oe_nxt = 1'b0;
          tick_nxt = 4'h0;
          state_nxt = HS_GAP;
        end
      HS_GAP:
        if (tick_r == HALF_LAST)
        begin
          done_nxt = 1'b1;
          state_nxt = HS_IDLE;
        end
      default:
        state_nxt = HS_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= HS_IDLE;
      tick_r <= 4'h0;
      bit_r <= 12'h000;
      last_r <= 12'h000;
      instr_r <= 16'h0000;
      wbyte_r <= 8'h00;
      rbyte_r <= 8'h00;
      rd_r <= 1'b0;
      lsb_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      wtake_r <= 1'b0;
      rvalid_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      last_r <= last_nxt;
      instr_r <= instr_nxt;
      wbyte_r <= wbyte_nxt;
      rbyte_r <= rbyte_nxt;
      rd_r <= rd_nxt;
      lsb_r <= lsb_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      wtake_r <= wtake_nxt;
      rvalid_r <= rvalid_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Pins and user-side outputs
  assign port.sclk = sclk_r;
  assign port.cs_n = cs_n_r;
  assign port.host_sdio_o = sdo_r;
  assign port.host_sdio_oe = oe_r;
  assign port.freq_sel = FREQ_PINS_HIGH;
  assign o_wtake = wtake_r;
  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_busy = (state_r != HS_IDLE);
  assign o_done = done_r;
endmodule

// *** tb/tscp_properties.sv ***
// Checker of the serial link signals between the two ends
`timescale 1ns/100ps
module tscp_properties (
  input logic i_clk, // System clock
  input logic i_resetn, // Reset, active low
  input logic sclk, // Serial clock
  input logic cs_n, // Chip select
  input logic host_sdio_o, // Host data
  input logic host_sdio_oe, // Host enable
  input logic dev_sdio_o, // Device data
  input logic dev_sdio_oe // Device enable
);
  logic [15:0] rise_r, rise_nxt; // Serial rises in frame
  logic sclk_r, cs_r; // Previous pin levels
  // Count serial rises, clear when a frame opens
  always_comb
  begin
    rise_nxt = rise_r;
    if (cs_r && !cs_n)
      rise_nxt = 16'h0000;
    else if (sclk && !sclk_r)
      rise_nxt = rise_r + 16'h0001;
  end
  // Register counter and pin history
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      {rise_r, sclk_r, cs_r} <= {16'h0000, 2'h1};
    else
      {rise_r, sclk_r, cs_r} <= {rise_nxt, sclk, cs_n};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_release; cs_n [*6] |-> !dev_sdio_oe; endproperty
  a_release: assert property (p_release) else $error("device drives while deselected");
  property p_one_drv; !(dev_sdio_oe && host_sdio_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive");
  property p_rd_phase; dev_sdio_oe |-> rise_r >= 16'h0010; endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("device drives in instruction");
  property p_frame; $rose(cs_n) |-> rise_r >= 16'h0018 && rise_r[2:0] == 3'h0; endproperty
  a_frame: assert property (p_frame) else $error("frame not whole bytes");
  property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("serial high phase length");
  property p_setup; $fell(cs_n) |-> !sclk [*4] ##1 sclk; endproperty
  a_setup: assert property (p_setup) else $error("select to clock setup");
  property p_host_hold; sclk && $past(sclk) && host_sdio_oe |-> $stable(host_sdio_o); endproperty
  a_host_hold: assert property (p_host_hold) else $error("host data moved in high phase");
  property p_dev_hold; sclk && $past(sclk) && $past(dev_sdio_oe) |-> $stable(dev_sdio_o); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device data moved in high phase");
endmodule

// *** tb/tscp_tb_top.sv ***
// Bench joining the host end and the device end over one link
`timescale 1ns/100ps
module tscp_tb_top;
  logic i_clk, i_resetn, i_ce, i_start, i_read, i_lsb_first; // Clock and host controls
  logic [1:0] i_len; // Length code
  logic [12:0] i_addr; // Start address
  logic [7:0] i_nbytes, i_wdata, o_rdata, o_update_count; // Counts and data
  logic o_wtake, o_rvalid, o_done, h_busy, d_busy, o_lsb_first, o_read_shadow, o_io_update; // Status
  logic [7:0] sh[64], ac[64], wq[16], upd_n, pulses; // Register model
  logic lsb_m; // Expected bit order
  integer seed;
  int error_cnt, checks_done, i, ph, n, a;
  tscp_if link();
  tscp_host_end tscp_host_end_inst (.i_clk, .i_resetn, .i_ce, .port(link.host), .i_start, .i_read, .i_len,
    .i_addr, .i_nbytes, .i_lsb_first, .i_wdata, .o_wtake, .o_rdata, .o_rvalid, .o_busy(h_busy), .o_done);
  tscp_dev_end tscp_dev_end_inst (.i_clk, .i_resetn, .i_ce, .port(link.dev), .o_lsb_first, .o_read_shadow,
    .o_io_update, .o_update_count, .o_busy(d_busy));
  tscp_properties tscp_properties_inst (.i_clk, .i_resetn, .sclk(link.sclk), .cs_n(link.cs_n),
    .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
    .dev_sdio_oe(link.dev_sdio_oe));
  // Clock at 40 MHz
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Count update pulses, cleared while reset is held
  always @(posedge i_clk)
    if (!i_resetn)
      pulses <= 8'h00;
    else if (o_io_update === 1'b1)
      pulses <= pulses + 8'h01;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Expected read value: status gives update count, unmapped gives zero
  function automatic logic [7:0] exp_rd(input int ad);
    if (ad == 32'h34)
      return upd_n;
    if (ad == 32'h5 || ad > 32'h34)
      return 8'h00;
    return ac[4][0] ? sh[ad] : ac[ad];
  endfunction
  // Model write: shadow only, update byte copies all shadows
  task automatic mdl_wr(input int ad, input logic [7:0] d);
    if (ad < 32'h34 && ad != 32'h5)
      sh[ad] = d;
    if (ad == 32'h5 && d[0])
    begin
      ac = sh;
      upd_n++;
    end
  endtask
  // One host cycle of nb bytes from a0, checked against the model
  task automatic xfer(input logic rd, input logic [1:0] len, input int a0, input int nb);
    int k, c, ad;
    k = 0;
    c = 0;
    ad = a0;
    @(posedge i_clk);
    {i_start, i_read, i_len, i_addr, i_nbytes, i_lsb_first} <= {1'b1, rd, len, 13'(a0), 8'(nb), lsb_m};
    i_wdata <= wq[0];
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    chk("device idle", 8'h00, {7'h00, d_busy});
    chk("host busy", 8'h01, {7'h00, h_busy});
    while (o_done !== 1'b1 && c < 2000)
    begin
      @(posedge i_clk);
      i_wdata <= wq[k];
      @(negedge i_clk);
      c++;
      if (o_rvalid === 1'b1)
      begin
        chk("read byte", exp_rd(ad), o_rdata);
        ad = lsb_m ? ad + 1 : ad - 1;
      end
      if (o_wtake === 1'b1 || o_rvalid === 1'b1)
        k++;
    end
    chk("cycle done", 8'h01, {7'h00, o_done});
    chk("host idle", 8'h00, {7'h00, h_busy});
    chk("bytes moved", 8'(nb), 8'(k));
    if (!rd)
      for (int j = 0; j < nb; j++)
        mdl_wr(lsb_m ? a0 + j : a0 - j, wq[j]);
    lsb_m = ac[0][6] | ac[0][1];
    chk("update count", upd_n, o_update_count);
    chk("update pulses", upd_n, pulses);
    chk("bit order", {7'h00, lsb_m}, {7'h00, o_lsb_first});
    chk("read shadow", {7'h00, ac[4][0]}, {7'h00, o_read_shadow});
  endtask
  // Write the update bit
  task automatic upd;
    wq[0] = 8'h01;
    xfer(1'b0, 2'h0, 32'h5, 1);
  endtask
  task automatic final_report;
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, about 80000 clocks
  initial
  begin
    #2000000;
    error_cnt++;
    final_report();
  end
  // Main sequence
  initial
  begin
    {seed, error_cnt, checks_done, upd_n, lsb_m} = {32'h0F02C8D8, 73'h0};
    {i_resetn, i_ce, i_start, i_read, i_len, i_addr, i_nbytes, i_lsb_first, i_wdata} = {2'h1, 34'h0};
    sh = '{default: 8'h00};
    sh[0] = 8'h18;
    ac = sh;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    xfer(1'b1, 2'h0, 32'h0, 1);
    wq[0] = 8'hA5;
    xfer(1'b0, 2'h0, 32'h34, 1);
    upd();
    xfer(1'b1, 2'h1, 32'h34, 2);
    xfer(1'b1, 2'h0, 32'h40, 1);
    for (ph = 0; ph < 2; ph++)
    begin
      for (i = 0; i < 8; i++)
      begin
        n = (i % 4 == 3) ? 4 + i : i % 4 + 1;
        a = 16 + $unsigned($random(seed)) % 28;
        for (int j = 0; j < n; j++)
          wq[j] = 8'($random(seed));
        xfer(1'b0, 2'(i % 4), a, n);
        xfer(1'b1, 2'(i % 4), a, n);
        upd();
        xfer(1'b1, 2'(i % 4), a, n);
      end
      wq[0] = 8'(ph ^ 1);
      xfer(1'b0, 2'h0, 32'h4, 1);
      wq[0] = 8'h5A;
      xfer(1'b0, 2'h0, 32'h0, 1);
      upd();
    end
    final_report();
  end
endmodule
